/* tb/dpw_checker_asserts.sv */
module dpw_checker
(
    // Clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Power and pins
    input wire logic        sleep_mode,
    input wire logic        adc_busy,
    input wire logic        pulse_out_a,
    input wire logic        pulse_out_b,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Bus and pin checks
    // ==========================================================
    // Software may still write mask, status or enables while asleep, so the freeze only
    // counts in cycles that hold neither an address phase nor a data phase.
    logic data_ph;
    logic frozen;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            data_ph <= 1'b0;
        else
            data_ph <= hsel && htrans[1] && hready;
    end

    assign frozen = sleep_mode && !adc_busy && !hsel && !data_ph;

    hready_one_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    rdata_idle_a: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> hrdata == 32'h0)
        else $error("hrdata not zero outside a read");
    reset_quiet_a: assert property ($rose(hresetn) |-> !pulse_out_a && !pulse_out_b && !irq)
        else $error("outputs active after reset");
    sleep_hold_a: assert property (frozen [*3] |-> $stable(pulse_out_a) && $stable(pulse_out_b) && $stable(irq))
        else $error("activity while asleep");
    pa_high_a: assert property ($rose(pulse_out_a) |=> pulse_out_a)
        else $error("pin a high for one cycle");
    pa_low_a: assert property ($fell(pulse_out_a) |=> !pulse_out_a)
        else $error("pin a low for one cycle");
    pb_high_a: assert property ($rose(pulse_out_b) |=> pulse_out_b)
        else $error("pin b high for one cycle");
    pb_low_a: assert property ($fell(pulse_out_b) |=> !pulse_out_b)
        else $error("pin b low for one cycle");

    cover property ($rose(pulse_out_a));
    cover property ($rose(pulse_out_b));
    cover property ($rose(irq));
    cover property (frozen [*3]);
endmodule

bind dpw_top dpw_checker chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .sleep_mode, .adc_busy, .pulse_out_a, .pulse_out_b, .irq);

/* tb/dpw_load_model.sv */
module dpw_load_model
(
    // Clock, reset and driven pin
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    // Measured shape in clock cycles
    output int        high_cyc,
    output int        period_cyc,
    output int        rises
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Resistive load that times the pin levels
    // ==========================================================
    int   since_rise;
    logic pin_q;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rises = 0;
            since_rise = 0;
            pin_q = 1'b0;
        end
        else
        begin
            since_rise = since_rise + 1;
            if (pin && !pin_q)
            begin
                period_cyc = since_rise;
                since_rise = 0;
                rises = rises + 1;
            end
            if (!pin && pin_q)
                high_cyc = since_rise;
            pin_q = pin;
        end
    end
endmodule

/* tb/dual_pwm_with_period_timers_test.sv */
module dual_pwm_with_period_timers_test
    import dpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Stimulus, bus tasks and comparisons
    // ==========================================================
    typedef struct { logic [2:0] ps; logic [9:0] p; logic [9:0] d; int hi; int per; } dpw_row_s;
    // Every prescale code once; the expected shape is duty*r and (period+1)*r, r = 2 << code.
    dpw_row_s rows [8] = '{'{0, 9, 3, 6, 20}, '{1, 4, 2, 8, 20}, '{2, 3, 1, 8, 32},
        '{3, 2, 2, 32, 48}, '{4, 1, 1, 32, 64}, '{5, 2, 1, 64, 192},
        '{6, 1, 1, 128, 256}, '{7, 1, 1, 256, 512}};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        sleep_mode = 1'b0;
    logic        adc_busy = 1'b0;
    logic [31:0] hrdata, rd, kept;
    logic        hreadyout, hresp, pulse_out_a, pulse_out_b, irq;
    int          err_total = 0, comparisons = 0, high_cyc, period_cyc, rises;
    int          high_b, period_b, rises_b;

    always #50 hclk = ~hclk;

    dpw_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .sleep_mode, .adc_busy,
        .pulse_out_a, .pulse_out_b, .irq);
    dpw_load_model load (.hclk, .hresetn, .pin(pulse_out_a), .high_cyc, .period_cyc, .rises);
    dpw_load_model load_b (.hclk, .hresetn, .pin(pulse_out_b), .high_cyc(high_b),
        .period_cyc(period_b), .rises(rises_b));

    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic setup(input logic [2:0] ps, input logic [9:0] p, input logic [9:0] d,
        input logic [1:0] oe);
        do_reset();
        wr(DPW_PERIOD_A_IDX, {22'h0, p});
        wr(DPW_DUTY_A_IDX, {22'h0, d});
        wr(DPW_PERIOD_B_IDX, {22'h0, p});
        wr(DPW_DUTY_B_IDX, {22'h0, d});
        wr(DPW_OUT_CTRL_IDX, {30'h0, oe});
        wr(DPW_CTRL_IDX, {24'h0, 1'b1, ps, 1'b1, ps});
    endtask

    task automatic wait_rises(input int n, input int lim);
        // The model counts on the rising edge, so its count is read once it has settled.
        for (int i = 0; i < lim && rises < n; i++)
            @(negedge hclk);
        @(posedge hclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        err_total++;
        give_verdict();
    end

    initial
    begin
        do_reset();
        rdchk(DPW_CTRL_IDX, 32'h0);
        rdchk(DPW_PERIOD_A_IDX, 32'h3FF);
        rdchk(DPW_STATUS_IDX, 32'h0);
        rdchk(8'h00, 32'h0);
        foreach (rows[i])
        begin
            setup(rows[i].ps, rows[i].p, rows[i].d, 2'h3);
            wait_rises(2, 4 * rows[i].per);
            check(period_cyc, rows[i].per);
            check(high_cyc, rows[i].hi);
            check(period_b, rows[i].per);
            check(high_b, rows[i].hi);
            rdchk(DPW_STATUS_IDX, 32'h3);
        end
        setup(3'h0, 10'h9, 10'h3, 2'h1);
        wait_rises(2, 80);
        wr(DPW_DUTY_A_IDX, 32'h7);
        rdchk(DPW_SHADOW_IDX, 32'h0003_0003);
        wait_rises(4, 80);
        check(high_cyc, 32'hE);
        check({31'h0, pulse_out_b}, 32'h0);
        check(rises_b, 32'h0);
        rdchk(DPW_STATUS_IDX, 32'h3);
        wr(DPW_CTRL_IDX, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(DPW_MASK_IDX, 32'h2);
        @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        wr(DPW_STATUS_IDX, 32'h2);
        @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        rdchk(DPW_STATUS_IDX, 32'h1);
        bus(1'b0, DPW_COUNT_A_IDX, 32'h0);
        kept = rd;
        repeat (30) @(posedge hclk);
        wr(DPW_COUNT_A_IDX, 32'h155);
        rdchk(DPW_COUNT_A_IDX, kept);
        wr(DPW_CTRL_IDX, 32'h88);
        rdchk(DPW_CTRL_IDX, 32'h88);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        bus(1'b0, DPW_COUNT_A_IDX, 32'h0);
        kept = rd;
        repeat (10) @(posedge hclk);
        rdchk(DPW_COUNT_A_IDX, kept);
        adc_busy <= 1'b1;
        repeat (10) @(posedge hclk);
        bus(1'b0, DPW_COUNT_A_IDX, 32'h0);
        check({31'h0, rd == kept}, 32'h0);
        sleep_mode <= 1'b0;
        setup(3'h0, 10'h4, 10'h0, 2'h3);
        repeat (60) @(posedge hclk);
        check(rises, 32'h0);
        check(rises_b, 32'h0);
        give_verdict();
    end
endmodule

/* verilog/dpw_channel.sv */
module dpw_channel
    import dpw_pkg::*;
(
    // Clock and reset
    input  wire logic           hclk,
    input  wire logic           hresetn,
    // Configuration and state
    input  wire dpw_chan_cfg_s  cfg,
    input  wire logic           halt,
    output dpw_chan_stat_s      stat
);

    // ==========================================================
    // Counter, shadow and output
    // ==========================================================
    logic       tick;
    logic       run;
    logic [9:0] cnt_reg;
    logic [9:0] shadow_reg;
    logic       out_reg;
    logic       wrap;

    assign run = cfg.on && !halt;

    dpw_prescaler u_ps
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (run),
        .ps_sel  (cfg.ps_sel),
        .tick    (tick)
    );

    assign wrap = tick && (cnt_reg == cfg.period_value);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_reg <= '0;
        else if (wrap)
            cnt_reg <= '0;
        else if (tick)
            cnt_reg <= cnt_reg + 10'h001;
    end

    // The new duty is only ever taken at the wrap, never mid-period.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            shadow_reg <= DPW_DUTY_RST;
        else if (wrap)
            shadow_reg <= cfg.duty_value;
    end

    // The pin only follows the waveform while the output is enabled.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            out_reg <= 1'b0;
        else if (!cfg.out_en)
            out_reg <= 1'b0;
        else if (wrap)
            out_reg <= (cfg.duty_value != 10'h000);
        else if (tick && (cnt_reg + 10'h001 == shadow_reg))
            out_reg <= 1'b0;
    end

    assign stat.channel_counter = cnt_reg;
    assign stat.duty_shadow     = shadow_reg;
    assign stat.pulse_out       = out_reg;
    assign stat.match           = wrap;

endmodule

/* verilog/dpw_pkg.sv */
package dpw_pkg;

    // ==========================================================
    // Register map: word indices, the byte address is four times the index
    // ==========================================================
    localparam logic [7:0] DPW_TIMER_AB_CONTROL_ADDR = 8'h05;
    localparam logic [7:0] DPW_CTRL_IDX      = 8'h05;
    localparam logic [7:0] DPW_PERIOD_A_IDX  = 8'h10;
    localparam logic [7:0] DPW_DUTY_A_IDX    = 8'h11;
    localparam logic [7:0] DPW_COUNT_A_IDX   = 8'h12;
    localparam logic [7:0] DPW_PERIOD_B_IDX  = 8'h13;
    localparam logic [7:0] DPW_DUTY_B_IDX    = 8'h14;
    localparam logic [7:0] DPW_COUNT_B_IDX   = 8'h15;
    localparam logic [7:0] DPW_OUT_CTRL_IDX  = 8'h16;
    localparam logic [7:0] DPW_STATUS_IDX    = 8'h17;
    localparam logic [7:0] DPW_MASK_IDX      = 8'h18;
    localparam logic [7:0] DPW_SHADOW_IDX    = 8'h19;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int DPW_CNT_W       = 10;
    localparam int DPW_PS_W        = 3;
    localparam int DPW_DIV_W       = 8;
    localparam int DPW_ON_A_BIT    = 7;
    localparam int DPW_PS_A_LSB    = 4;
    localparam int DPW_ON_B_BIT    = 3;
    localparam int DPW_PS_B_LSB    = 0;
    localparam logic [7:0] DPW_CTRL_RST    = 8'h00;
    localparam logic [9:0] DPW_PERIOD_RST  = 10'h3FF;
    localparam logic [9:0] DPW_DUTY_RST    = 10'h000;
    localparam logic [1:0] DPW_OUTEN_RST   = 2'h0;
    localparam logic [1:0] DPW_MASK_RST    = 2'h0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed
    {
        logic       on;
        logic [2:0] ps_sel;
        logic       out_en;
        logic [9:0] period_value;
        logic [9:0] duty_value;
    } dpw_chan_cfg_s;

    typedef struct packed
    {
        logic [9:0] channel_counter;
        logic [9:0] duty_shadow;
        logic       pulse_out;
        logic       match;
    } dpw_chan_stat_s;

    typedef enum logic [1:0]
    {
        DPW_BUS_IDLE  = 2'b00,
        DPW_BUS_WRITE = 2'b01,
        DPW_BUS_READ  = 2'b10
    } dpw_bus_e;

endpackage

/* verilog/dpw_prescaler.sv */
module dpw_prescaler
    import dpw_pkg::*;
(
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // Control
    input  wire logic                run,
    input  wire logic [DPW_PS_W-1:0] ps_sel,
    // Tick
    output logic                     tick
);

    // ==========================================================
    // Divider
    // ==========================================================
    logic [DPW_DIV_W-1:0] div_reg;
    logic [DPW_DIV_W-1:0] div_last;

    // Code 0 divides by 2, each step doubles up to 256.
    assign div_last = DPW_DIV_W'((9'h002 << ps_sel) - 9'h001);

    // The count clears while stopped so every start begins a full step.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_reg <= '0;
        else if (!run)
            div_reg <= '0;
        else if (div_reg >= div_last)
            div_reg <= '0;
        else
            div_reg <= div_reg + 8'h01;
    end

    assign tick = run && (div_reg >= div_last);

endmodule

/* verilog/dpw_top.sv */
// Our own choice: the AHB-Lite interface to the registers.
module dpw_top
    import dpw_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Power state
    input  wire logic        sleep_mode,
    input  wire logic        adc_busy,
    // Outputs
    output logic             pulse_out_a,
    output logic             pulse_out_b,
    output logic             irq
);

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]     ctrl_reg;
    logic [9:0]     period_a_reg;
    logic [9:0]     period_b_reg;
    logic [9:0]     duty_a_reg;
    logic [9:0]     duty_b_reg;
    logic [1:0]     outen_reg;
    logic [1:0]     status_reg;
    logic [1:0]     mask_reg;
    dpw_bus_e       phase_reg;
    logic [7:0]     idx_reg;
    dpw_chan_cfg_s  cfg [2];
    dpw_chan_stat_s stat [2];
    logic           halt;
    logic           wr_en;
    logic [1:0]     clr;
    logic [31:0]    rd_val;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================================
    // Bus address phase capture
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_reg <= DPW_BUS_IDLE;
            idx_reg   <= '0;
        end
        else if (hready)
        begin
            if (hsel && htrans[1])
                phase_reg <= hwrite ? DPW_BUS_WRITE : DPW_BUS_READ;
            else
                phase_reg <= DPW_BUS_IDLE;
            idx_reg <= haddr[9:2];
        end
    end

    assign wr_en = (phase_reg == DPW_BUS_WRITE);

    // ==========================================================
    // Writable registers
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg     <= DPW_CTRL_RST;
            period_a_reg <= DPW_PERIOD_RST;
            period_b_reg <= DPW_PERIOD_RST;
            duty_a_reg   <= DPW_DUTY_RST;
            duty_b_reg   <= DPW_DUTY_RST;
            outen_reg    <= DPW_OUTEN_RST;
            mask_reg     <= DPW_MASK_RST;
        end
        else if (wr_en)
        begin
            case (idx_reg)
                DPW_CTRL_IDX:     ctrl_reg     <= hwdata[7:0];
                DPW_PERIOD_A_IDX: period_a_reg <= hwdata[9:0];
                DPW_PERIOD_B_IDX: period_b_reg <= hwdata[9:0];
                DPW_DUTY_A_IDX:   duty_a_reg   <= hwdata[9:0];
                DPW_DUTY_B_IDX:   duty_b_reg   <= hwdata[9:0];
                DPW_OUT_CTRL_IDX: outen_reg    <= hwdata[1:0];
                DPW_MASK_IDX:     mask_reg     <= hwdata[1:0];
                default:          ctrl_reg     <= ctrl_reg;
            endcase
        end
    end

    // ==========================================================
    // Channels
    // ==========================================================
    assign halt = sleep_mode && !adc_busy;

    always_comb
    begin
        cfg[0].on           = ctrl_reg[DPW_ON_A_BIT];
        cfg[0].ps_sel       = ctrl_reg[DPW_PS_A_LSB +: DPW_PS_W];
        cfg[0].out_en       = outen_reg[0];
        cfg[0].period_value = period_a_reg;
        cfg[0].duty_value   = duty_a_reg;
        cfg[1].on           = ctrl_reg[DPW_ON_B_BIT];
        cfg[1].ps_sel       = ctrl_reg[DPW_PS_B_LSB +: DPW_PS_W];
        cfg[1].out_en       = outen_reg[1];
        cfg[1].period_value = period_b_reg;
        cfg[1].duty_value   = duty_b_reg;
    end

    // Two identical channels; only their configuration words differ.
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        dpw_channel u_chan
        (
            .hclk    (hclk),
            .hresetn (hresetn),
            .cfg     (cfg[ch]),
            .halt    (halt),
            .stat    (stat[ch])
        );
    end

    assign pulse_out_a = stat[0].pulse_out;
    assign pulse_out_b = stat[1].pulse_out;

    // ==========================================================
    // Period match flags and interrupt
    // ==========================================================
    assign clr = (wr_en && idx_reg == DPW_STATUS_IDX) ? hwdata[1:0] : 2'h0;

    // A match in the clearing cycle wins so no event is lost.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_reg <= 2'h0;
        else
            status_reg <= (status_reg & ~clr) | {stat[1].match, stat[0].match};
    end

    assign irq = |(status_reg & mask_reg);

    // ==========================================================
    // Read data
    // ==========================================================
    always_comb
    begin
        case (idx_reg)
            DPW_CTRL_IDX:     rd_val = {24'h0, ctrl_reg};
            DPW_PERIOD_A_IDX: rd_val = {22'h0, period_a_reg};
            DPW_PERIOD_B_IDX: rd_val = {22'h0, period_b_reg};
            DPW_DUTY_A_IDX:   rd_val = {22'h0, duty_a_reg};
            DPW_DUTY_B_IDX:   rd_val = {22'h0, duty_b_reg};
            DPW_COUNT_A_IDX:  rd_val = {22'h0, stat[0].channel_counter};
            DPW_COUNT_B_IDX:  rd_val = {22'h0, stat[1].channel_counter};
            DPW_OUT_CTRL_IDX: rd_val = {30'h0, outen_reg};
            DPW_STATUS_IDX:   rd_val = {30'h0, status_reg};
            DPW_MASK_IDX:     rd_val = {30'h0, mask_reg};
            DPW_SHADOW_IDX:   rd_val = {6'h00, stat[1].duty_shadow, 6'h00,
                                        stat[0].duty_shadow};
            default:          rd_val = 32'h00000000;
        endcase
    end

    assign hrdata = (phase_reg == DPW_BUS_READ) ? rd_val : 32'h00000000;

endmodule
